// File: common/reseq_gpio_regs.vh
// constants for the fault resequencing and pin control block
// assumes a 125 MHz system clock and no register bus
`ifndef RESEQ_GPIO_REGS_VH
`define RESEQ_GPIO_REGS_VH

`define NUM_RAILS 10
`define NUM_PINS 22
`define NUM_IN_ONLY 4
`define CLK_MHZ 125
`define STEP_MS 5
`define STEP_CYCLES (`STEP_MS * 1000 * `CLK_MHZ)
`define STABLE_MS 1000
`define STABLE_CYCLES (`STABLE_MS * 1000 * `CLK_MHZ)
`define MAX_RAIL_EN 10
`define MAX_GPI 8
`define MAX_GPO 10
`define MODE_OPEN_DRAIN 2'h0
`define MODE_PUSH_HIGH 2'h1
`define MODE_PUSH_LOW 2'h2
`define FUNC_NONE 2'h0
`define FUNC_RAIL_EN 2'h1
`define FUNC_INPUT 2'h2
`define FUNC_OUTPUT 2'h3
`define ATTEMPT_RESET 3'h0

`endif

// File: hdl/pin_bank.v
// general purpose pin bank: per-pin function, output mode and source select
// assumes pin levels from pads are already synchronised by the caller
`timescale 1ns/1ps
`include "reseq_gpio_regs.vh"

module pin_bank (
	// clock and reset
	input wire sys_clk_in,
	input wire rst_in,
	// configuration
	input wire [2*`NUM_PINS-1:0] pin_func_in,
	input wire [2*`NUM_PINS-1:0] pin_mode_in,
	input wire [`NUM_PINS-1:0] pin_use_logic_in,
	input wire [`NUM_PINS-1:0] host_level_in,
	input wire [`NUM_PINS-1:0] logic_level_in,
	input wire [`NUM_PINS-1:0] rail_en_level_in,
	// pad side
	output reg [`NUM_PINS-1:0] pin_out,
	output reg [`NUM_PINS-1:0] pin_oe_out,
	// count check
	output reg config_error_out
);
	reg [4:0] n_en;
	reg [4:0] n_in;
	reg [4:0] n_out;
	integer k;

	// per-function counts, too many of one kind is a config error
	always @* begin
		n_en = 5'h0;
		n_in = 5'h0;
		n_out = 5'h0;
		for (k = 0; k < `NUM_PINS; k = k + 1) begin
			if (pin_func_in[2*k +: 2] == `FUNC_RAIL_EN) n_en = n_en + 5'h1;
			if (pin_func_in[2*k +: 2] == `FUNC_INPUT) n_in = n_in + 5'h1;
			if (pin_func_in[2*k +: 2] == `FUNC_OUTPUT) n_out = n_out + 5'h1;
		end
	end

	genvar g;
	generate
		for (g = 0; g < `NUM_PINS; g = g + 1) begin : pin_gen
			wire [1:0] func = pin_func_in[2*g +: 2];
			wire [1:0] mode = pin_mode_in[2*g +: 2];
			// output source: host or boolean block, enables from sequencer
			wire lvl = (func == `FUNC_RAIL_EN) ? rail_en_level_in[g] :
				(pin_use_logic_in[g] ? logic_level_in[g] : host_level_in[g]);
			wire drives = (func == `FUNC_RAIL_EN) || (func == `FUNC_OUTPUT);
			// open drain only pulls low, else release the line
			always @(posedge sys_clk_in) begin
				if (rst_in) begin
					pin_out[g] <= 1'b0;
					pin_oe_out[g] <= 1'b0;
				end else if (!drives) begin
					pin_out[g] <= 1'b0;
					pin_oe_out[g] <= 1'b0;
				end else if (mode == `MODE_OPEN_DRAIN) begin
					pin_out[g] <= 1'b0;
					pin_oe_out[g] <= ~lvl;
				end else begin
					pin_out[g] <= lvl;
					pin_oe_out[g] <= 1'b1;
				end
			end
		end
	endgenerate

	// register the limit check so it is glitch free
	always @(posedge sys_clk_in) begin
		if (rst_in)
			config_error_out <= 1'b0;
		else
			config_error_out <= (n_en > `MAX_RAIL_EN) || (n_in > `MAX_GPI) ||
				(n_out > `MAX_GPO);
	end
endmodule // pin_bank

// File: hdl/reseq_ctrl.v
// resequence controller: shuts rail sets off, waits, sequences them back on
// assumes rail fault, power-good and below-12.5 percent flags are clocked
// here already; pin levels come from pads and are synchronised below
`timescale 1ns/1ps
`include "reseq_gpio_regs.vh"

module reseq_ctrl #(
	parameter STEP_CYCLES = `STEP_CYCLES,
	parameter STABLE_CYCLES = `STABLE_CYCLES
) (
	// clock and reset
	input wire sys_clk_in,
	input wire rst_in,
	// rail status
	input wire [`NUM_RAILS-1:0] rail_fault_in,
	input wire [`NUM_RAILS-1:0] rail_reseq_cfg_in,
	input wire [`NUM_RAILS-1:0] retries_done_in,
	input wire [`NUM_RAILS-1:0] power_good_in,
	input wire [`NUM_RAILS-1:0] rail_low_in,
	input wire [`NUM_RAILS*`NUM_RAILS-1:0] slave_map_in,
	// host request
	input wire reseq_req_in,
	input wire [`NUM_RAILS-1:0] reseq_req_set_in,
	// configuration
	input wire [7:0] reseq_delay_in,
	input wire [1:0] max_attempts_in,
	input wire [7:0] turn_off_time_limit_in,
	input wire continue_on_warn_in,
	// sequencer handshake
	output reg [`NUM_RAILS-1:0] soft_off_out,
	output reg [`NUM_RAILS-1:0] seq_on_out,
	output reg turn_off_time_warning_out,
	output reg [2:0] attempt_count_out,
	output reg reseq_busy_out,
	output reg reseq_locked_out,
	// pins
	input wire [`NUM_PINS-1:0] pin_in,
	input wire [`NUM_IN_ONLY-1:0] in_only_pin_in,
	output wire [`NUM_PINS+`NUM_IN_ONLY-1:0] pin_level_out,
	input wire [2*`NUM_PINS-1:0] pin_func_in,
	input wire [2*`NUM_PINS-1:0] pin_mode_in,
	input wire [`NUM_PINS-1:0] pin_use_logic_in,
	input wire [`NUM_PINS-1:0] host_level_in,
	input wire [`NUM_PINS-1:0] logic_level_in,
	input wire [`NUM_PINS*4-1:0] pin_rail_in,
	output wire [`NUM_PINS-1:0] pin_out,
	output wire [`NUM_PINS-1:0] pin_oe_out,
	output wire pin_config_error_out
);
	localparam ST_IDLE = 2'h0;
	localparam ST_OFF = 2'h1;
	localparam ST_WAIT = 2'h2;
	localparam ST_ON = 2'h3;

	reg [1:0] state;
	reg [`NUM_RAILS-1:0] active_set;
	reg [`NUM_RAILS-1:0] new_set;
	reg [31:0] timer;
	reg [7:0] steps;
	reg [31:0] stable_timer;
	reg stable_watch;
	reg [`NUM_PINS+`NUM_IN_ONLY-1:0] pin_meta;
	reg [`NUM_PINS+`NUM_IN_ONLY-1:0] pin_sync;
	reg [`NUM_PINS-1:0] rail_en_level;
	integer i;
	integer p;

	// pad levels pass two flops before use as dependencies
	always @(posedge sys_clk_in) begin
		if (rst_in) begin
			pin_meta <= {(`NUM_PINS+`NUM_IN_ONLY){1'b0}};
			pin_sync <= {(`NUM_PINS+`NUM_IN_ONLY){1'b0}};
		end else begin
			pin_meta <= {in_only_pin_in, pin_in};
			pin_sync <= pin_meta;
		end
	end
	assign pin_level_out = pin_sync;

	// collect faulted rails plus their slaves; active rails masked while busy
	// the set is kept after success for the stability watch, so masking it
	// in idle would swallow a real fault during that second
	always @* begin
		new_set = {`NUM_RAILS{1'b0}};
		for (i = 0; i < `NUM_RAILS; i = i + 1) begin
			if (rail_fault_in[i] && rail_reseq_cfg_in[i] && retries_done_in[i]
				&& !(reseq_busy_out && active_set[i]))
				new_set = new_set | slave_map_in[i*`NUM_RAILS +: `NUM_RAILS] |
					(`NUM_RAILS'h1 << i);
		end
		if (reseq_req_in)
			new_set = new_set | reseq_req_set_in;
	end

	wire all_off = &(rail_low_in | ~active_set);
	wire all_good = &(power_good_in | ~active_set);
	wire exhausted = attempt_count_out > {1'b0, max_attempts_in};

	// main sequence
	always @(posedge sys_clk_in) begin
		if (rst_in) begin
			state <= ST_IDLE;
			active_set <= {`NUM_RAILS{1'b0}};
			timer <= 32'h0;
			steps <= 8'h0;
			soft_off_out <= {`NUM_RAILS{1'b0}};
			seq_on_out <= {`NUM_RAILS{1'b0}};
			turn_off_time_warning_out <= 1'b0;
			attempt_count_out <= `ATTEMPT_RESET;
			reseq_busy_out <= 1'b0;
			reseq_locked_out <= 1'b0;
			stable_watch <= 1'b0;
			stable_timer <= 32'h0;
		end else begin
			turn_off_time_warning_out <= 1'b0;
			case (state)
			ST_IDLE: begin
				if (new_set != {`NUM_RAILS{1'b0}} && !reseq_locked_out) begin
					active_set <= new_set;
					soft_off_out <= new_set;
					seq_on_out <= {`NUM_RAILS{1'b0}};
					reseq_busy_out <= 1'b1;
					stable_watch <= 1'b0;
					timer <= 32'h0;
					steps <= 8'h0;
					state <= ST_OFF;
				end
			end
			ST_OFF: begin
				// a set joining here is shut down with the first one
				active_set <= active_set | new_set;
				soft_off_out <= active_set | new_set;
				timer <= timer + 32'h1;
				if (timer == STEP_CYCLES - 1) begin
					timer <= 32'h0;
					steps <= steps + 8'h1;
				end
				if (all_off) begin
					timer <= 32'h0;
					steps <= 8'h0;
					state <= ST_WAIT;
				end else if (steps >= turn_off_time_limit_in && turn_off_time_limit_in != 8'h0) begin
					turn_off_time_warning_out <= 1'b1;
					steps <= 8'h0;
					if (!continue_on_warn_in) begin
						soft_off_out <= {`NUM_RAILS{1'b0}};
						active_set <= {`NUM_RAILS{1'b0}};
						reseq_busy_out <= 1'b0;
						state <= ST_IDLE;
					end
				end
			end
			ST_WAIT: begin
				// programmable delay in 5 ms steps before turning on
				timer <= timer + 32'h1;
				if (timer == STEP_CYCLES - 1) begin
					timer <= 32'h0;
					steps <= steps + 8'h1;
				end
				if (steps >= reseq_delay_in) begin
					soft_off_out <= {`NUM_RAILS{1'b0}};
					timer <= 32'h0;
					// a set arriving with no attempts left stays off
					if (exhausted || attempt_count_out == {1'b0, max_attempts_in} + 3'h1) begin
						reseq_locked_out <= 1'b1;
						reseq_busy_out <= 1'b0;
						state <= ST_IDLE;
					end else begin
						seq_on_out <= active_set;
						attempt_count_out <= attempt_count_out + 3'h1;
						state <= ST_ON;
					end
				end
			end
			default: begin
				// wait for regulation; a fresh fault retries the set
				if (all_good) begin
					seq_on_out <= {`NUM_RAILS{1'b0}};
					stable_watch <= 1'b1;
					stable_timer <= 32'h0;
					reseq_busy_out <= 1'b0;
					state <= ST_IDLE;
				end else if ((|(rail_fault_in & active_set)) || new_set != 0) begin
					if (exhausted || attempt_count_out == {1'b0, max_attempts_in} + 3'h1) begin
						reseq_locked_out <= 1'b1;
						reseq_busy_out <= 1'b0;
						seq_on_out <= {`NUM_RAILS{1'b0}};
						state <= ST_IDLE;
					end else begin
						active_set <= active_set | new_set;
						soft_off_out <= active_set | new_set;
						seq_on_out <= {`NUM_RAILS{1'b0}};
						steps <= 8'h0;
						state <= ST_OFF;
					end
				end
			end
			endcase
			// one second of clean regulation clears the counter
			if (stable_watch && state == ST_IDLE && !reseq_locked_out) begin
				if (!all_good) begin
					stable_timer <= 32'h0;
				end else if (stable_timer == STABLE_CYCLES - 1) begin
					// active set left alone: a start in this cycle owns it
					attempt_count_out <= `ATTEMPT_RESET;
					stable_watch <= 1'b0;
				end else begin
					stable_timer <= stable_timer + 32'h1;
				end
			end
		end
	end

	// enable level for pins assigned to a rail without a monitor input
	always @* begin
		for (p = 0; p < `NUM_PINS; p = p + 1)
			rail_en_level[p] = (pin_rail_in[4*p +: 4] < `NUM_RAILS) ?
				~soft_off_out[pin_rail_in[4*p +: 4]] : 1'b0;
	end

	pin_bank u_pins (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.pin_func_in(pin_func_in),
		.pin_mode_in(pin_mode_in),
		.pin_use_logic_in(pin_use_logic_in),
		.host_level_in(host_level_in),
		.logic_level_in(logic_level_in),
		.rail_en_level_in(rail_en_level),
		.pin_out(pin_out),
		.pin_oe_out(pin_oe_out),
		.config_error_out(pin_config_error_out)
	);
endmodule // reseq_ctrl

// File: dv/reseq_checker.sv
// checker for the resequence controller, port relations only
// assumes it is bound to reseq_ctrl and sees its ports unchanged
`timescale 1ns/1ps
`include "reseq_gpio_regs.vh"
module reseq_checker #(
	parameter STEP_CYCLES = 4,
	parameter STABLE_CYCLES = 20
) (
	input wire sys_clk_in,
	input wire rst_in,
	input wire [`NUM_RAILS-1:0] rail_fault_in,
	input wire [`NUM_RAILS-1:0] rail_reseq_cfg_in,
	input wire [`NUM_RAILS-1:0] retries_done_in,
	input wire reseq_req_in,
	input wire [1:0] max_attempts_in,
	input wire [`NUM_RAILS-1:0] soft_off_out,
	input wire [`NUM_RAILS-1:0] seq_on_out,
	input wire turn_off_time_warning_out,
	input wire [2:0] attempt_count_out,
	input wire reseq_busy_out,
	input wire reseq_locked_out
);
	// one domain, so one default clock and reset
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	wire idle = !reseq_busy_out && !reseq_locked_out;
	wire hit = |(rail_fault_in & rail_reseq_cfg_in & retries_done_in);
	property p_reset; $fell(rst_in) |-> attempt_count_out == 3'h0 && !reseq_locked_out; endproperty
	a_reset: assert property (p_reset) else $error("counter not clear after reset");
	property p_start; idle && hit |=> reseq_busy_out && soft_off_out != 0; endproperty
	a_start: assert property (p_start) else $error("fault did not start shutdown");
	property p_retry; idle && !hit && !reseq_req_in |=> !reseq_busy_out; endproperty
	a_retry: assert property (p_retry) else $error("started without cause");
	property p_inc; $rose(|seq_on_out) |-> attempt_count_out == $past(attempt_count_out) + 3'h1;
	endproperty
	a_inc: assert property (p_inc) else $error("counter not stepped at sequence-on");
	property p_max; attempt_count_out <= {1'b0, max_attempts_in} + 3'h1; endproperty
	a_max: assert property (p_max) else $error("attempts above limit");
	property p_lock; reseq_locked_out |=> reseq_locked_out; endproperty
	a_lock: assert property (p_lock) else $error("lock released without reset");
	property p_lock_idle; reseq_locked_out && !reseq_busy_out |=> !reseq_busy_out; endproperty
	a_lock_idle: assert property (p_lock_idle) else $error("resequenced while locked");
	property p_warn; turn_off_time_warning_out |-> $past(|soft_off_out); endproperty
	a_warn: assert property (p_warn) else $error("warning outside shutdown");
	property p_order; (soft_off_out & seq_on_out) == 0; endproperty
	a_order: assert property (p_order) else $error("rail off and on together");
	c_seq: cover property ($rose(|seq_on_out));
	c_warn: cover property (turn_off_time_warning_out);
	c_lock: cover property ($rose(reseq_locked_out));
endmodule // reseq_checker
bind reseq_ctrl reseq_checker #(.STEP_CYCLES(STEP_CYCLES), .STABLE_CYCLES(STABLE_CYCLES)) chk (
	.sys_clk_in(sys_clk_in), .rst_in(rst_in), .rail_fault_in(rail_fault_in),
	.rail_reseq_cfg_in(rail_reseq_cfg_in), .retries_done_in(retries_done_in),
	.reseq_req_in(reseq_req_in), .max_attempts_in(max_attempts_in),
	.soft_off_out(soft_off_out), .seq_on_out(seq_on_out),
	.turn_off_time_warning_out(turn_off_time_warning_out),
	.attempt_count_out(attempt_count_out), .reseq_busy_out(reseq_busy_out),
	.reseq_locked_out(reseq_locked_out));

// File: dv/rail_model.sv
// behavioural rails: fall after soft off, regulate after sequence-on
// assumes commands come from the controller; hold and bad come from the bench
`timescale 1ns/1ps
module rail_model (
	input wire sys_clk_in,
	input wire rst_in,
	input wire [9:0] soft_off_in,
	input wire [9:0] seq_on_in,
	input wire [9:0] hold_in,
	input wire [9:0] bad_in,
	output reg [9:0] rail_low_out,
	output reg [9:0] power_good_out
);
	reg [9:0] off_d;
	reg [9:0] on_d;
	// held rails never discharge, bad rails lose power good at soft off and do not regain it at sequence-on
	always @(posedge sys_clk_in) begin
		off_d <= soft_off_in & ~hold_in;
		on_d <= seq_on_in;
		if (rst_in) begin
			rail_low_out <= 10'h000;
			power_good_out <= 10'h3ff;
		end else begin
			rail_low_out <= (rail_low_out | off_d) & ~on_d;
			power_good_out <= (power_good_out & ~soft_off_in) | (on_d & ~bad_in);
		end
	end
endmodule // rail_model

// File: dv/fault_resequence_gpio_control_tb_top.sv
// bench for the resequence controller and its pins
// assumes small step and stable counts, rails from rail_model
`timescale 1ns/1ps
`include "reseq_gpio_regs.vh"
module fault_resequence_gpio_control_tb_top;
	reg clk = 0, rst = 1, req = 0, cont = 0;
	reg [9:0] flt = 0, cfg = 10'h3ff, rdone = 10'h3ff, rset = 0, bad = 0, hold = 0;
	reg [99:0] smap = 0;
	reg [7:0] dly = 8'h02, lim = 8'h00;
	reg [1:0] maxa = 2'h1;
	reg [21:0] pin = 0, ul = 0, hl = 0, ll = 0;
	reg [3:0] io = 0;
	reg [43:0] fn = 0, md = 0;
	reg [87:0] pr = 0;
	wire [9:0] soff, son, low, pg;
	wire warn, busy, lock, perr;
	wire [2:0] cnt;
	wire [25:0] plev;
	wire [21:0] pout, poe;
	// pad level: our drive wins where enabled
	wire [21:0] pad = (poe & pout) | (~poe & pin);
	integer fails = 0, compares = 0, cyc = 0, n;
	initial forever #4 clk = ~clk;
	reseq_ctrl #(.STEP_CYCLES(4), .STABLE_CYCLES(20)) dut (.sys_clk_in(clk), .rst_in(rst),
		.rail_fault_in(flt), .rail_reseq_cfg_in(cfg), .retries_done_in(rdone),
		.power_good_in(pg), .rail_low_in(low), .slave_map_in(smap), .reseq_req_in(req),
		.reseq_req_set_in(rset), .reseq_delay_in(dly), .max_attempts_in(maxa),
		.turn_off_time_limit_in(lim), .continue_on_warn_in(cont), .soft_off_out(soff),
		.seq_on_out(son), .turn_off_time_warning_out(warn), .attempt_count_out(cnt),
		.reseq_busy_out(busy), .reseq_locked_out(lock), .pin_in(pad), .in_only_pin_in(io),
		.pin_level_out(plev), .pin_func_in(fn), .pin_mode_in(md), .pin_use_logic_in(ul),
		.host_level_in(hl), .logic_level_in(ll), .pin_rail_in(pr), .pin_out(pout),
		.pin_oe_out(poe), .pin_config_error_out(perr));
	rail_model rails (.sys_clk_in(clk), .rst_in(rst), .soft_off_in(soff), .seq_on_in(son),
		.hold_in(hold), .bad_in(bad), .rail_low_out(low), .power_good_out(pg));
	task end_of_test;
		$display("fails=%0d compares=%0d", fails, compares);
		if (fails == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task chk(input reg c, input [8*20-1:0] m);
		compares = compares + 1;
		if (c !== 1'b1) begin
			fails = fails + 1;
			$display("[FAIL] %0t %0s", $time, m);
		end
	endtask
	task wt(input integer k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	// one-cycle fault pulse on the given rails
	task pulse(input [9:0] f);
		@(posedge clk) flt <= f;
		@(posedge clk) flt <= 10'h000;
	endtask
	task t_fault;
		smap[9:0] <= 10'h002;
		pulse(10'h001);
		for (n = 0; n < 4 && soff === 10'h000; n++) wt(1);
		chk(soff === 10'h003, "shutdown set");
		for (n = 0; n < 20 && low !== 10'h003; n++) wt(1);
		for (n = 0; n < 30 && son === 10'h000; n++) wt(1);
		chk(n >= 8 && n <= 10, "resequence delay");
		chk(son === 10'h003 && cnt === 3'h1, "sequence-on");
		for (n = 0; n < 20 && busy !== 1'b0; n++) wt(1);
		wt(30);
		chk(cnt === 3'h0, "counter cleared");
	endtask
	task t_retry;
		rdone <= 10'h3fe;
		pulse(10'h001);
		wt(6);
		chk(busy === 1'b0, "retries pending");
		rdone <= 10'h3ff;
	endtask
	task t_warn;
		hold <= 10'h003;
		lim <= 8'h01;
		pulse(10'h001);
		for (n = 0; n < 30 && warn !== 1'b1; n++) wt(1);
		chk(warn === 1'b1, "turn-off warning");
		for (n = 0; n < 30 && busy !== 1'b0; n++) wt(1);
		chk(busy === 1'b0 && son === 10'h000, "stop after warning");
		cont <= 1'b1;
		pulse(10'h001);
		for (n = 0; n < 30 && warn !== 1'b1; n++) wt(1);
		chk(warn === 1'b1 && busy === 1'b1, "continue on warning");
		hold <= 10'h000;
		lim <= 8'h00;
		for (n = 0; n < 40 && son === 10'h000; n++) wt(1);
		chk(son === 10'h003 && cnt === 3'h1, "reseq after warning");
		for (n = 0; n < 20 && busy !== 1'b0; n++) wt(1);
		wt(30);
		cont <= 1'b0;
	endtask
	// second set joins while the first still waits for its rails to fall
	task t_join;
		hold <= 10'h007;
		pulse(10'h001);
		wt(2);
		pulse(10'h004);
		wt(2);
		chk(soff === 10'h007 && busy === 1'b1, "joined shutdown");
		hold <= 10'h000;
		for (n = 0; n < 40 && son === 10'h000; n++) wt(1);
		chk(son === 10'h007 && cnt === 3'h1, "shared attempt");
		for (n = 0; n < 20 && busy !== 1'b0; n++) wt(1);
		wt(30);
	endtask
	task t_lock;
		maxa <= 2'h0;
		bad <= 10'h003;
		pulse(10'h001);
		for (n = 0; n < 40 && son === 10'h000; n++) wt(1);
		pulse(10'h001);
		for (n = 0; n < 20 && lock !== 1'b1; n++) wt(1);
		chk(lock === 1'b1 && cnt === 3'h1, "saturated");
		bad <= 10'h000;
		pulse(10'h001);
		wt(5);
		chk(busy === 1'b0 && soff === 10'h000, "locked ignores");
		@(posedge clk) rst <= 1'b1;
		@(posedge clk) rst <= 1'b0;
		wt(1);
		chk(lock === 1'b0 && cnt === 3'h0, "reset clears lock");
	endtask
	task t_pins;
		fn[1:0] <= `FUNC_OUTPUT;
		md[1:0] <= `MODE_PUSH_HIGH;
		hl[0] <= 1'b1;
		io <= 4'h5;
		fn[3:2] <= `FUNC_RAIL_EN;
		md[3:2] <= `MODE_PUSH_HIGH;
		pr[7:4] <= 4'h0;
		fn[5:4] <= `FUNC_OUTPUT;
		md[5:4] <= `MODE_OPEN_DRAIN;
		hl[2] <= 1'b0;
		wt(4);
		chk(pout[0] === 1'b1 && poe[0] === 1'b1, "host output");
		chk(plev[0] === 1'b1 && plev[25:22] === 4'h5, "pin levels");
		chk(pout[1] === 1'b1 && poe[1] === 1'b1, "rail enable pin");
		chk(pout[2] === 1'b0 && poe[2] === 1'b1 && perr === 1'b0, "open drain low");
		ul[0] <= 1'b1;
		ll[0] <= 1'b0;
		wt(2);
		chk(pout[0] === 1'b0 && poe[0] === 1'b1, "logic source");
		fn[21:0] <= {11{`FUNC_OUTPUT}};
		wt(4);
		chk(perr === 1'b1, "output count");
	endtask
	// cycle ceiling well above the sum of all scenarios
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 5000) begin
			fails = fails + 1;
			end_of_test;
		end
	end
	initial begin
		wt(16);
		rst <= 1'b0;
		wt(1);
		chk(cnt === 3'h0 && busy === 1'b0 && soff === 10'h000, "reset values");
		t_fault;
		t_retry;
		t_warn;
		t_join;
		t_lock;
		t_pins;
		end_of_test;
	end
endmodule // fault_resequence_gpio_control_tb_top
